// >>> pkg/bsel_pkg.sv
// Shared constants and types for the serial boot loader block.
// Assumes a single 20 MHz system clock and an 8N1 link to the host.
package bsel_pkg;
	// System clock and link rate
	localparam int SYS_CLK_HZ = 20000000;
	localparam int LINK_BAUD = 1200;
	// Bit time in clock cycles, a longest time so it rounds down
	localparam int BIT_CYC = SYS_CLK_HZ / LINK_BAUD;
	// Programming pulse per byte, in microseconds as specified
	localparam int PROG_TIME_US = 2000;
	// Least time in whole cycles, with cycles per microsecond rounded down
	localparam int PROG_CYC = (PROG_TIME_US * (SYS_CLK_HZ / 1000000) + 0) ;
	// Sync byte that opens a download
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	// Default length of the downloaded boot program
	localparam int BOOT_LEN = 25;
	// Byte positions of the index values inside the boot program
	localparam int IDX_X_POS = 16;
	localparam int IDX_Y_POS = 20;
	// Program memory size and base address
	localparam int MEM_DEPTH = 8192;
	localparam logic [15:0] IMAGE_BASE = 16'hE000;
	// Receive queue shape
	localparam int FIFO_DEPTH = 16;
	localparam int DATA_W = 8;
	// Counter width for bit and pulse timers
	localparam int CNT_W = 20;
	// Serial frame: start, eight data, stop
	localparam int FRAME_BITS = 10;

	// Download phase, one-hot
	typedef enum logic [3:0] {
		BSEL_PH_SYNC = 4'h1,
		BSEL_PH_BOOT = 4'h2,
		BSEL_PH_EXEC = 4'h4,
		BSEL_PH_PROG = 4'h8
	} bsel_phase_t;

	// Receiver state, one-hot
	typedef enum logic [3:0] {
		BSEL_RX_IDLE = 4'h1,
		BSEL_RX_START = 4'h2,
		BSEL_RX_DATA = 4'h4,
		BSEL_RX_STOP = 4'h8
	} bsel_rx_t;

	// Programming engine state, one-hot
	typedef enum logic [2:0] {
		BSEL_PG_IDLE = 3'h1,
		BSEL_PG_WAIT = 3'h2,
		BSEL_PG_SEND = 3'h4
	} bsel_pg_t;

	// Memory write port carrier
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} bsel_wr_t;

	// Complete state of the loader
	typedef struct packed {
		bsel_phase_t phase;
		bsel_rx_t rx_st;
		logic [CNT_W-1:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic tx_busy;
		logic [CNT_W-1:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic tx_line;
		logic [7:0] boot_cnt;
		logic [15:0] idx_x;
		logic [15:0] idx_y;
		logic port_c0;
		logic exec_pulse;
		bsel_pg_t pg_st;
		logic [CNT_W-1:0] pg_cnt;
		logic [15:0] pg_addr;
		bsel_wr_t wr;
		logic overrun;
		logic [15:0] prog_count;
	} bsel_state_t;
endpackage

// >>> hw/bsel_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact, no bypass path.
`timescale 1ns/1ps
module bsel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Storage array and pointers
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// Handshakes; full refuses pushes so the source sees back-pressure
	always_comb begin
		in_ready = (cnt_r != (AW+1)'(DEPTH));
		out_valid = (cnt_r != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		out_data = mem[rp_r];
	end

	// Pointer and occupancy update
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Data array, no reset needed
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule

// >>> hw/bsel_loader.sv
// Serial boot download and program memory loader.
// Assumes rxd is synchronous to sys_clk and idles high; 8N1 framing.
//
// Behaviour
// - Sync byte 0xFF starts download at 1200 baud
// - Echo every boot program byte unchanged
// - Run boot program once fully received
// - Boot program: port C0 low, indexes, jump
// - Receiver queues bytes while one is programmed
// - Read back each programmed byte to host
`timescale 1ns/1ps
module bsel_loader #(
	parameter int BIT_CYC = bsel_pkg::BIT_CYC,
	parameter int PROG_CYC = bsel_pkg::PROG_CYC,
	parameter int BOOT_LEN = bsel_pkg::BOOT_LEN,
	parameter int MEM_DEPTH = bsel_pkg::MEM_DEPTH,
	parameter int FIFO_DEPTH = bsel_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rxd,
	output logic txd,
	output logic port_c0,
	output logic exec_start,
	output logic [15:0] index_x,
	output logic [15:0] index_y,
	output logic [3:0] phase,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_data,
	output logic rx_overrun,
	output logic [15:0] prog_count
);
	localparam int MAW = $clog2(MEM_DEPTH);
	localparam logic [bsel_pkg::CNT_W-1:0] BIT_C = bsel_pkg::CNT_W'(BIT_CYC);
	localparam logic [bsel_pkg::CNT_W-1:0] HALF_C = bsel_pkg::CNT_W'(BIT_CYC / 2);
	localparam logic [bsel_pkg::CNT_W-1:0] PROG_C = bsel_pkg::CNT_W'(PROG_CYC);

	bsel_pkg::bsel_state_t st_r; // Registered state
	bsel_pkg::bsel_state_t st_nxt; // Next state

	// Program memory modelled as an array inside the block
	logic [7:0] pmem [MEM_DEPTH];
	logic [7:0] rd_byte; // Readback of current location
	logic [MAW-1:0] mem_idx; // Offset from image base

	// Receive queue handshake
	logic rx_done; // Complete byte this cycle
	logic q_in_valid;
	logic q_in_ready;
	logic q_out_valid;
	logic q_out_ready;
	logic [7:0] q_out_data;

	// Receive queue lets the next byte land while one is programmed
	bsel_fifo #(
		.WIDTH(bsel_pkg::DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rxq (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(q_in_valid),
		.in_ready(q_in_ready),
		.in_data(st_r.rx_sh),
		.out_valid(q_out_valid),
		.out_ready(q_out_ready),
		.out_data(q_out_data)
	);

	// Memory index and readback path
	always_comb begin
		mem_idx = MAW'(st_r.pg_addr - bsel_pkg::IMAGE_BASE);
		rd_byte = pmem[mem_idx];
	end

	// Byte lands in queue only during programming phase
	always_comb begin
		rx_done = (st_r.rx_st == bsel_pkg::BSEL_RX_STOP) && (st_r.rx_cnt == '0) && rxd;
		q_in_valid = rx_done && (st_r.phase == bsel_pkg::BSEL_PH_PROG);
		q_out_ready = (st_r.pg_st == bsel_pkg::BSEL_PG_IDLE) && (st_r.phase == bsel_pkg::BSEL_PH_PROG);
	end

	// All next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.exec_pulse = 1'b0;
		st_nxt.wr.we = 1'b0;

		// Receiver: sample mid-bit, one start, eight data, one stop
		case (st_r.rx_st)
			bsel_pkg::BSEL_RX_IDLE: begin
				if (!rxd) begin
					st_nxt.rx_st = bsel_pkg::BSEL_RX_START;
					st_nxt.rx_cnt = HALF_C;
				end
			end
			bsel_pkg::BSEL_RX_START: begin
				if (st_r.rx_cnt != '0) begin
					st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
				end else if (rxd) begin
					// Glitch, not a real start bit
					st_nxt.rx_st = bsel_pkg::BSEL_RX_IDLE;
				end else begin
					st_nxt.rx_st = bsel_pkg::BSEL_RX_DATA;
					// Count reaches zero on the last cycle, so load one less for a whole bit time
					st_nxt.rx_cnt = BIT_C - 1'b1;
					st_nxt.rx_bit = 3'h0;
				end
			end
			bsel_pkg::BSEL_RX_DATA: begin
				if (st_r.rx_cnt != '0) begin
					st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
				end else begin
					// Least significant bit arrives first
					st_nxt.rx_sh = {rxd, st_r.rx_sh[7:1]};
					// A longer bit would drift into the next start bit on back-to-back bytes
					st_nxt.rx_cnt = BIT_C - 1'b1;
					st_nxt.rx_bit = st_r.rx_bit + 3'h1;
					if (st_r.rx_bit == 3'h7) begin
						st_nxt.rx_st = bsel_pkg::BSEL_RX_STOP;
					end
				end
			end
			bsel_pkg::BSEL_RX_STOP: begin
				if (st_r.rx_cnt != '0) begin
					st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
				end else begin
					// A low stop bit is a framing error; the byte is dropped
					st_nxt.rx_st = bsel_pkg::BSEL_RX_IDLE;
				end
			end
			default: begin
				st_nxt.rx_st = bsel_pkg::BSEL_RX_IDLE;
			end
		endcase

		// Transmitter: shift out a framed byte
		if (st_r.tx_busy) begin
			if (st_r.tx_cnt != '0) begin
				st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
			end else begin
				st_nxt.tx_line = st_r.tx_sh[0];
				st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
				st_nxt.tx_cnt = BIT_C - 1'b1;
				st_nxt.tx_bit = st_r.tx_bit + 4'h1;
				if (st_r.tx_bit == 4'(bsel_pkg::FRAME_BITS)) begin
					// Stop bit has had its full time
					st_nxt.tx_busy = 1'b0;
					st_nxt.tx_line = 1'b1;
				end
			end
		end

		// Download phases
		case (st_r.phase)
			bsel_pkg::BSEL_PH_SYNC: begin
				// Only an all-ones byte at the fixed rate opens a download
				if (rx_done && st_r.rx_sh == bsel_pkg::SYNC_BYTE) begin
					st_nxt.phase = bsel_pkg::BSEL_PH_BOOT;
					st_nxt.boot_cnt = 8'h00;
				end
			end
			bsel_pkg::BSEL_PH_BOOT: begin
				if (rx_done) begin
					// Echo restarts the transmitter without checking tx_busy; at equal rates the previous stop bit still has one cycle left
					st_nxt.tx_busy = 1'b1;
					st_nxt.tx_sh = {1'b1, st_r.rx_sh, 1'b0};
					st_nxt.tx_cnt = '0;
					st_nxt.tx_bit = 4'h0;
					// Capture index values as their bytes pass
					case (32'(st_r.boot_cnt))
						bsel_pkg::IDX_X_POS: st_nxt.idx_x[15:8] = st_r.rx_sh;
						bsel_pkg::IDX_X_POS + 1: st_nxt.idx_x[7:0] = st_r.rx_sh;
						bsel_pkg::IDX_Y_POS: st_nxt.idx_y[15:8] = st_r.rx_sh;
						bsel_pkg::IDX_Y_POS + 1: st_nxt.idx_y[7:0] = st_r.rx_sh;
						default: begin
						end
					endcase
					st_nxt.boot_cnt = st_r.boot_cnt + 8'h01;
					if (st_r.boot_cnt == 8'(BOOT_LEN - 1)) begin
						st_nxt.phase = bsel_pkg::BSEL_PH_EXEC;
					end
				end
			end
			bsel_pkg::BSEL_PH_EXEC: begin
				// Boot program effect: indicator low, then enter programming routine
				st_nxt.port_c0 = 1'b0;
				st_nxt.exec_pulse = 1'b1;
				st_nxt.pg_addr = st_r.idx_y;
				st_nxt.pg_st = bsel_pkg::BSEL_PG_IDLE;
				st_nxt.phase = bsel_pkg::BSEL_PH_PROG;
			end
			bsel_pkg::BSEL_PH_PROG: begin
				// Bytes that find the queue full are lost and flagged
				if (q_in_valid && !q_in_ready) begin
					st_nxt.overrun = 1'b1;
				end
			end
			default: begin
				st_nxt.phase = bsel_pkg::BSEL_PH_SYNC;
			end
		endcase

		// Programming engine: write, hold for the pulse time, read back
		case (st_r.pg_st)
			bsel_pkg::BSEL_PG_IDLE: begin
				if (q_out_ready && q_out_valid) begin
					st_nxt.wr.we = 1'b1;
					st_nxt.wr.addr = st_r.pg_addr;
					st_nxt.wr.data = q_out_data;
					st_nxt.pg_cnt = PROG_C;
					st_nxt.pg_st = bsel_pkg::BSEL_PG_WAIT;
				end
			end
			bsel_pkg::BSEL_PG_WAIT: begin
				if (st_r.pg_cnt != '0) begin
					st_nxt.pg_cnt = st_r.pg_cnt - 1'b1;
				end else begin
					st_nxt.pg_st = bsel_pkg::BSEL_PG_SEND;
				end
			end
			bsel_pkg::BSEL_PG_SEND: begin
				// Waits for the previous readback to leave the line
				if (!st_r.tx_busy) begin
					st_nxt.tx_busy = 1'b1;
					st_nxt.tx_sh = {1'b1, rd_byte, 1'b0};
					st_nxt.tx_cnt = '0;
					st_nxt.tx_bit = 4'h0;
					st_nxt.pg_addr = st_r.pg_addr + 16'h0001;
					st_nxt.prog_count = st_r.prog_count + 16'h0001;
					st_nxt.pg_st = bsel_pkg::BSEL_PG_IDLE;
				end
			end
			default: begin
				st_nxt.pg_st = bsel_pkg::BSEL_PG_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.phase <= bsel_pkg::BSEL_PH_SYNC;
			st_r.rx_st <= bsel_pkg::BSEL_RX_IDLE;
			st_r.pg_st <= bsel_pkg::BSEL_PG_IDLE;
			st_r.tx_line <= 1'b1;
			st_r.tx_sh <= 10'h3FF;
			st_r.port_c0 <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Program memory write, taken from the next-state write carrier on the same edge that registers it
	always_ff @(posedge sys_clk) begin
		if (st_nxt.wr.we) begin
			pmem[MAW'(st_nxt.wr.addr - bsel_pkg::IMAGE_BASE)] <= st_nxt.wr.data;
		end
	end

	// Outputs straight from the state register
	assign txd = st_r.tx_line;
	assign port_c0 = st_r.port_c0;
	assign exec_start = st_r.exec_pulse;
	assign index_x = st_r.idx_x;
	assign index_y = st_r.idx_y;
	assign phase = st_r.phase;
	assign mem_we = st_r.wr.we;
	assign mem_addr = st_r.wr.addr;
	assign mem_data = st_r.wr.data;
	assign rx_overrun = st_r.overrun;
	assign prog_count = st_r.prog_count;
endmodule

// >>> test/bsel_loader_asserts.sv
// Port-level checks on the serial boot loader: phase flow, writes, readback.
// Assumes one clock domain; bound from the bench top with the bench's counts.
`timescale 1ns/1ps
module bsel_loader_asserts #(
	parameter int BIT_CYC = 20,
	parameter int PROG_CYC = 50
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rxd,
	input wire logic txd,
	input wire logic port_c0,
	input wire logic exec_start,
	input wire logic [15:0] index_x,
	input wire logic [15:0] index_y,
	input wire logic [3:0] phase,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_data,
	input wire logic rx_overrun,
	input wire logic [15:0] prog_count
);
	logic [19:0] low_run_r; // Cycles txd has been low in a row
	logic [15:0] last_addr_r; // Address of the previous write
	logic seen_we_r; // A write has happened since reset

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Helper state; a long low run would mean a frame with no stop bit
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_run_r <= 20'h00000;
			last_addr_r <= 16'h0000;
			seen_we_r <= 1'b0;
		end else begin
			low_run_r <= txd ? 20'h00000 : low_run_r + 20'h00001;
			if (mem_we) begin
				last_addr_r <= mem_addr;
				seen_we_r <= 1'b1;
			end
		end
	end

	property p_phase_onehot; $onehot(phase); endproperty
	a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");
	property p_sync_silent; phase == 4'h1 |-> txd; endproperty
	a_sync_silent: assert property (p_sync_silent) else $error("txd active before sync");
	property p_exec_pulse; exec_start |=> !exec_start; endproperty
	a_exec_pulse: assert property (p_exec_pulse) else $error("exec pulse too long");
	property p_exec_phase; exec_start |=> (phase == 4'h4 || phase == 4'h8) [*8]; endproperty
	a_exec_phase: assert property (p_exec_phase) else $error("phase wrong after exec");
	property p_c0_low; exec_start |-> ##[0:1] !port_c0; endproperty
	a_c0_low: assert property (p_c0_low) else $error("port bit not driven low");
	property p_c0_high; (phase == 4'h1 || phase == 4'h2) |-> port_c0; endproperty
	a_c0_high: assert property (p_c0_high) else $error("port bit low too early");
	property p_we_prog; mem_we |-> phase == 4'h8; endproperty
	a_we_prog: assert property (p_we_prog) else $error("write outside programming");
	property p_addr_step; mem_we && seen_we_r |-> mem_addr == last_addr_r + 16'h0001; endproperty
	a_addr_step: assert property (p_addr_step) else $error("write address not sequential");
	property p_addr_stands; !mem_we |-> $stable(mem_addr) && $stable(mem_data); endproperty
	a_addr_stands: assert property (p_addr_stands) else $error("write bus moved without write");
	property p_readback_due; mem_we |-> ##[1:1000] $changed(prog_count); endproperty
	a_readback_due: assert property (p_readback_due) else $error("no readback after write");
	property p_count_step; $changed(prog_count) |-> prog_count == $past(prog_count) + 16'h0001; endproperty
	a_count_step: assert property (p_count_step) else $error("program count jumped");
	property p_tx_low_max; low_run_r <= 20'(9 * BIT_CYC + 2); endproperty
	a_tx_low_max: assert property (p_tx_low_max) else $error("txd low past a frame");

	// Main scenarios reached
	c_exec: cover property (exec_start);
	c_write_run: cover property (mem_we && seen_we_r);
	c_readback: cover property ($changed(prog_count));
endmodule

// >>> test/bsel_host_model.sv
// Host side of the link: frames bytes onto rxd and collects frames from txd.
// Assumes the bench clock as timebase; the line idles high between frames.
`timescale 1ns/1ps
module bsel_host_model #(
	parameter int BIT_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] rx_q[$]; // Bytes returned by the device
	logic [7:0] img[0:63]; // Image built from object records
	int bad_count = 0; // Readback mismatches
	int lost_count = 0; // Readbacks that never came

	initial rxd = 1'b1;

	// One frame: start low, data LSB first, stop high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge sys_clk);
			rxd = fr[i];
			repeat (BIT_CYC - 1) @(negedge sys_clk);
		end
	endtask

	// Mid-bit sampling; a low stop bit drops the byte
	initial begin
		logic [7:0] v;
		forever begin
			@(negedge txd);
			repeat (BIT_CYC / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge sys_clk);
				v[i] = txd;
			end
			repeat (BIT_CYC) @(posedge sys_clk);
			if (txd === 1'b1) rx_q.push_back(v);
		end
	end

	// Bounded wait for one returned byte
	task automatic get_byte(output logic [7:0] b, output bit ok);
		ok = 1'b0;
		b = 8'h00;
		for (int t = 0; t < 40 * BIT_CYC && !ok; t++) begin
			if (rx_q.size() > 0) begin
				b = rx_q.pop_front();
				ok = 1'b1;
			end else @(posedge sys_clk);
		end
	endtask

	// Only data records are taken; others fall through untouched
	function automatic void load_rec(input string r);
		int n;
		int a;
		if (r.substr(0, 1) != "S1") return;
		n = r.substr(2, 3).atohex() - 3;
		a = r.substr(4, 7).atohex() - int'(bsel_pkg::IMAGE_BASE);
		for (int i = 0; i < n; i++) img[a + i] = 8'(r.substr(8 + 2 * i, 9 + 2 * i).atohex());
	endfunction

	// Keep one byte queued ahead; verify each readback, the last one too
	task automatic program_image(input int n);
		logic [7:0] b;
		bit ok;
		send_byte(img[0]);
		for (int i = 1; i <= n; i++) begin
			if (i < n) send_byte(img[i]);
			get_byte(b, ok);
			if (!ok) lost_count++;
			else if (b !== img[i - 1]) bad_count++;
		end
	endtask
endmodule

// >>> test/test_boot_serial_eprom_loader.sv
// Bench top: loader against the host model; the receive queue is reached through the loader.
// Assumes a 20 MHz clock and shortened bit and programming counts.
`timescale 1ns/1ps
module test_boot_serial_eprom_loader;
	localparam int BIT_CYC = 20; // Shortened bit time
	localparam int PROG_CYC = 50; // Shortened programming time
	logic sys_clk, rstn, rxd, txd, port_c0, exec_start, mem_we, rx_overrun;
	logic [15:0] index_x, index_y, mem_addr, prog_count;
	logic [3:0] phase;
	logic [7:0] mem_data;
	logic [7:0] boot[0:24]; // Boot program sent after the sync byte
	int failures = 0, samples_checked = 0, exec_seen = 0, wr_seen = 0;

	bsel_loader #(.BIT_CYC(BIT_CYC), .PROG_CYC(PROG_CYC)) DUT (.sys_clk(sys_clk), .rstn(rstn),
		.rxd(rxd), .txd(txd), .port_c0(port_c0), .exec_start(exec_start), .index_x(index_x),
		.index_y(index_y), .phase(phase), .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data),
		.rx_overrun(rx_overrun), .prog_count(prog_count));
	bsel_host_model #(.BIT_CYC(BIT_CYC)) host (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checked=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Every write must carry the next image byte at the next address
	always @(negedge sys_clk) begin
		if (exec_start === 1'b1) exec_seen++;
		if (mem_we === 1'b1) begin
			chk(mem_addr, bsel_pkg::IMAGE_BASE + 16'(wr_seen));
			chk({8'h00, mem_data}, {8'h00, host.img[wr_seen]});
			wr_seen++;
		end
	end

	task automatic t_reset();
		chk({txd, port_c0, exec_start, mem_we, rx_overrun, phase}, 16'h0181);
		chk(prog_count, 16'h0000);
	endtask

	// Back-to-back burst: each byte leaves the receive queue and is programmed before the next one lands
	task automatic t_burst();
		logic [7:0] b;
		bit ok;
		host.load_rec("S109E00AC1C2C3C4C5C600");
		for (int k = 10; k < 16; k++) host.send_byte(host.img[k]);
		for (int k = 10; k < 16; k++) begin
			host.get_byte(b, ok);
			chk({7'h00, ok, b}, {8'h01, host.img[k]});
		end
		chk(prog_count, 16'h0010);
		chk(16'(wr_seen), 16'h0010);
		chk(16'(rx_overrun), 16'h0000);
	endtask

	// A wrong opening byte must be ignored without echo
	task automatic t_sync_refused();
		host.send_byte(8'h55);
		repeat (3 * BIT_CYC) @(negedge sys_clk);
		chk({12'h000, phase}, 16'h0001);
		chk(16'(host.rx_q.size()), 16'h0000);
	endtask

	// Sync, then the boot program back to back; echoes, run and operands
	task automatic t_boot();
		for (int k = 0; k < 25; k++) boot[k] = 8'h80 + 8'(k);
		boot[16] = 8'h12;
		boot[17] = 8'h34;
		boot[20] = 8'hE0;
		boot[21] = 8'h00;
		host.send_byte(bsel_pkg::SYNC_BYTE);
		for (int k = 0; k < 25; k++) host.send_byte(boot[k]);
		for (int t = 0; t < 2000 && host.rx_q.size() < 25; t++) @(negedge sys_clk);
		chk(16'(host.rx_q.size()), 16'h0019);
		for (int k = 0; k < 25 && host.rx_q.size() > 0; k++) chk({8'h00, host.rx_q.pop_front()}, {8'h00, boot[k]});
		chk(16'(exec_seen), 16'h0001);
		chk({12'h000, phase}, 16'h0008);
		chk(16'(port_c0), 16'h0000);
		chk(index_x, 16'h1234);
		chk(index_y, 16'hE000);
	endtask

	// Object records to device memory with verified readback
	task automatic t_program();
		host.load_rec("S505E000EEEE");
		host.load_rec("S107E00011223344FF");
		host.load_rec("S109E0045566778899AABB");
		host.load_rec("S9030000FC");
		host.program_image(10);
		chk(16'(host.bad_count), 16'h0000);
		chk(16'(host.lost_count), 16'h0000);
		chk(prog_count, 16'h000A);
		chk(16'(wr_seen), 16'h000A);
		chk(16'(rx_overrun), 16'h0000);
	endtask

	initial begin
		rstn = 1'b0;
		repeat (4) @(negedge sys_clk);
		rstn = 1'b1;
		t_reset();
		t_sync_refused();
		t_boot();
		t_program();
		t_burst();
		final_report();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		failures++;
		final_report();
	end
endmodule

bind bsel_loader bsel_loader_asserts #(.BIT_CYC(BIT_CYC), .PROG_CYC(PROG_CYC)) u_chk (.sys_clk(sys_clk),
	.rstn(rstn), .rxd(rxd), .txd(txd), .port_c0(port_c0), .exec_start(exec_start), .index_x(index_x),
	.index_y(index_y), .phase(phase), .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data),
	.rx_overrun(rx_overrun), .prog_count(prog_count));
